// [hdl/pfb_pkg.sv]
// constants and types shared by the peripheral flag bank
package pfb_pkg;

    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 5;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] FLAGS_OFF = 12'h000;
    localparam logic [ADDR_W-1:0] MASK_OFF = 12'h004;
    localparam logic [ADDR_W-1:0] STAT_OFF = 12'h008;
    localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h00c;

    // ---------------------------------------------------------------
    // flag bit positions
    // ---------------------------------------------------------------
    localparam int BIT_NV_DONE = 4;
    localparam int BIT_BUS_COL = 3;
    localparam int BIT_LOW_VOLT = 2;
    localparam int BIT_TIMER_THREE_OVF = 1;
    localparam int BIT_CC2_EVT = 0;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
    localparam logic [FLAG_W-1:0] MASK_RST = 5'h00;
    localparam logic [FLAG_W-1:0] STAT_RST = 5'h00;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // ---------------------------------------------------------------
    // capture/compare unit mode
    // ---------------------------------------------------------------
    typedef enum logic [1:0]
    {
        CC_OFF,
        CC_CAPTURE,
        CC_COMPARE,
        CC_PWM
    } pfb_ccmode_t;

endpackage

// [hdl/pfb_evt_if.sv]
// event vector and capture/compare mode between conditioner and flag bank
interface pfb_evt_if;
    import pfb_pkg::*;

    logic [FLAG_W-1:0] evt;
    pfb_ccmode_t ccMode;

    modport cond
    (
        input ccMode,
        output evt
    );

    modport bank
    (
        output ccMode,
        input evt
    );

endinterface

// [hdl/pfb_event_cond.sv]
// turns peripheral event sources into flag set lines, edge-detecting only the low voltage level
module pfb_event_cond
    import pfb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // peripheral event sources
    input wire logic nvWriteDone,
    input wire logic busCollision,
    input wire logic lowVoltageLevel,
    input wire logic timerThreeRollover,
    input wire logic capEvent,
    input wire logic cmpMatch,
    // toward the flag bank
    pfb_evt_if.cond ev
);

    // ---------------------------------------------------------------
    // low voltage detector level synchroniser and edge
    // ---------------------------------------------------------------
    logic lvMeta_q;
    logic lvMeta_d;
    logic lvSync_q;
    logic lvSync_d;
    logic lvLast_q;
    logic lvLast_d;
    logic [FLAG_W-1:0] evt;

    always_comb
    begin
        lvMeta_d = lowVoltageLevel;
        lvSync_d = lvMeta_q;
        lvLast_d = lvSync_q;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            lvMeta_q <= 1'b0;
            lvSync_q <= 1'b0;
            lvLast_q <= 1'b0;
        end
        else
        begin
            lvMeta_q <= lvMeta_d;
            lvSync_q <= lvSync_d;
            lvLast_q <= lvLast_d;
        end
    end

    // ---------------------------------------------------------------
    // event vector
    // ---------------------------------------------------------------
    always_comb
    begin
        evt = '0;
        evt[BIT_NV_DONE] = nvWriteDone; // R2
        evt[BIT_BUS_COL] = busCollision; // R3
        evt[BIT_LOW_VOLT] = lvSync_q && !lvLast_q; // R4
        evt[BIT_TIMER_THREE_OVF] = timerThreeRollover; // R6
        case (ev.ccMode)
            CC_CAPTURE: evt[BIT_CC2_EVT] = capEvent; // R5
            CC_COMPARE: evt[BIT_CC2_EVT] = cmpMatch; // R5
            default: evt[BIT_CC2_EVT] = 1'b0; // R5
        endcase
    end

    assign ev.evt = evt;

endmodule // pfb_event_cond

// [hdl/pfb_flag_bank.sv]
// second peripheral interrupt flag bank with apb register access
//
// How it works
// [R1] bits 7 to 5 of the flag register read as zero and writes to them are ignored.
// [R2] bit 4 sets when a nonvolatile write finishes and only a software write clears it.
// [R3] bit 3 sets on a serial bus collision and stays set until software clears it.
// [R4] bit 2 sets when the supply falls below the detect threshold until software clears it.
// [R5] bit 0 sets on capture or compare match per mode, is unused in pwm, software clears it.
// [R6] bit 1 sets when timer three rolls over and holds until software writes it to zero.
// [R7] every flag sets on its event whatever the mask or global enable state.
module pfb_flag_bank
    import pfb_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral event sources
    input wire logic nvWriteDone,
    input wire logic busCollision,
    input wire logic lowVoltageLevel,
    input wire logic timerThreeRollover,
    input wire logic capEvent,
    input wire logic cmpMatch,
    // flag and interrupt outputs
    output logic [FLAG_W-1:0] eventFlags,
    output logic irq
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic hitReg(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] off);
        hitReg = (addr == off);
    endfunction

    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        isMapped = hitReg(addr, FLAGS_OFF) || hitReg(addr, MASK_OFF) ||
                   hitReg(addr, STAT_OFF) || hitReg(addr, CTRL_OFF);
    endfunction

    // ---------------------------------------------------------------
    // event conditioning
    // ---------------------------------------------------------------
    pfb_evt_if evIf ();

    pfb_event_cond u_cond
    (
        .clock(clock),
        .rst_b(rst_b),
        .nvWriteDone(nvWriteDone),
        .busCollision(busCollision),
        .lowVoltageLevel(lowVoltageLevel),
        .timerThreeRollover(timerThreeRollover),
        .capEvent(capEvent),
        .cmpMatch(cmpMatch),
        .ev(evIf.cond)
    );

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [FLAG_W-1:0] flags_q;
    logic [FLAG_W-1:0] flags_d;
    logic [FLAG_W-1:0] mask_q;
    logic [FLAG_W-1:0] mask_d;
    logic [FLAG_W-1:0] stat_q;
    logic [FLAG_W-1:0] stat_d;
    pfb_ccmode_t ccMode_q;
    pfb_ccmode_t ccMode_d;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic irq_q;
    logic irq_d;

    logic accStart;
    logic accDone;
    logic wrDone;
    logic [FLAG_W-1:0] evt;
    logic [DATA_W-1:0] rdMux;

    assign evIf.ccMode = ccMode_q;
    assign evt = evIf.evt;

    // ---------------------------------------------------------------
    // apb handshake: one wait state, then pready
    // ---------------------------------------------------------------
    assign accStart = psel && penable && !pready_q;
    assign accDone = psel && penable && pready_q;
    assign wrDone = accDone && pwrite && isMapped(paddr);

    always_comb
    begin
        rdMux = '0;
        if (hitReg(paddr, FLAGS_OFF))
        begin
            rdMux[FLAG_W-1:0] = flags_q; // R1
        end
        else if (hitReg(paddr, MASK_OFF))
        begin
            rdMux[FLAG_W-1:0] = mask_q;
        end
        else if (hitReg(paddr, STAT_OFF))
        begin
            rdMux[FLAG_W-1:0] = stat_q;
        end
        else if (hitReg(paddr, CTRL_OFF))
        begin
            rdMux[1:0] = ccMode_q;
        end
    end

    always_comb
    begin
        pready_d = accStart;
        pslverr_d = accStart && !isMapped(paddr);
        prdata_d = RDATA_RST;
        if (accStart && !pwrite)
        begin
            prdata_d = rdMux;
        end
    end

    // ---------------------------------------------------------------
    // flag, mask, status and control next values
    // ---------------------------------------------------------------
    always_comb
    begin
        flags_d = flags_q;
        mask_d = mask_q;
        stat_d = stat_q;
        ccMode_d = ccMode_q;
        if (wrDone && hitReg(paddr, FLAGS_OFF))
        begin
            flags_d = pwdata[FLAG_W-1:0]; // R1
        end
        if (wrDone && hitReg(paddr, MASK_OFF))
        begin
            mask_d = pwdata[FLAG_W-1:0];
        end
        if (wrDone && hitReg(paddr, STAT_OFF))
        begin
            stat_d = stat_q & ~pwdata[FLAG_W-1:0];
        end
        if (wrDone && hitReg(paddr, CTRL_OFF))
        begin
            ccMode_d = pfb_ccmode_t'(pwdata[1:0]);
        end
        // hardware set wins over a same-cycle software clear
        flags_d = flags_d | evt; // R2 R3 R4 R5 R6 R7
        stat_d = stat_d | evt; // R7
        irq_d = |(stat_d & mask_d);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            flags_q <= FLAGS_RST;
            mask_q <= MASK_RST;
            stat_q <= STAT_RST;
            ccMode_q <= CC_OFF;
            prdata_q <= RDATA_RST;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            flags_q <= flags_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            ccMode_q <= ccMode_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign eventFlags = flags_q;
    assign irq = irq_q;

endmodule // pfb_flag_bank

// [tb/pfb_flag_bank_assertions.sv]
// concurrent checks on the flag bank ports
module pfb_flag_bank_chk
    import pfb_pkg::*;
(
    // watched ports
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic nvWriteDone,
    input wire logic busCollision,
    input wire logic lowVoltageLevel,
    input wire logic timerThreeRollover,
    input wire logic capEvent,
    input wire logic cmpMatch,
    input wire logic [FLAG_W-1:0] eventFlags
);
    // ----
    // helpers
    // ----
    logic flagWr;
    logic anyEvt;
    assign flagWr = psel && penable && pready && pwrite && paddr == FLAGS_OFF;
    assign anyEvt = nvWriteDone || busCollision || timerThreeRollover || capEvent || cmpMatch;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence lvRise;
        !lowVoltageLevel ##1 lowVoltageLevel;
    endsequence
    // ----
    // properties
    // ----
    a_upper_zero: assert property (pready |-> prdata[DATA_W-1:FLAG_W] == '0)
        else $error("upper read bits not zero");
    a_nv_sets: assert property (nvWriteDone |=> eventFlags[BIT_NV_DONE])
        else $error("write done flag not set");
    a_col_sets: assert property (busCollision |=> eventFlags[BIT_BUS_COL])
        else $error("collision flag not set");
    a_lv_sets: assert property (lvRise |-> ##[1:5] eventFlags[BIT_LOW_VOLT])
        else $error("low voltage flag not set");
    a_tmr_sets: assert property (timerThreeRollover |=> eventFlags[BIT_TIMER_THREE_OVF])
        else $error("timer flag not set");
    a_cc_cause: assert property ($rose(eventFlags[BIT_CC2_EVT]) |-> $past(capEvent || cmpMatch || flagWr))
        else $error("capture flag rose without cause");
    a_flag_hold: assert property (!flagWr |=> (eventFlags & $past(eventFlags)) == $past(eventFlags))
        else $error("flag dropped without write");
    a_flag_load: assert property (flagWr && !anyEvt |=>
        (eventFlags | 5'h04) == ($past(pwdata[FLAG_W-1:0]) | 5'h04))
        else $error("flag write not loaded");
endmodule // pfb_flag_bank_chk

bind pfb_flag_bank pfb_flag_bank_chk pfb_flag_bank_chk_inst (.clock(clock), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .nvWriteDone(nvWriteDone), .busCollision(busCollision),
    .lowVoltageLevel(lowVoltageLevel), .timerThreeRollover(timerThreeRollover),
    .capEvent(capEvent), .cmpMatch(cmpMatch), .eventFlags(eventFlags));

// [tb/pfb_evt_src.sv]
// model of the peripheral event sources feeding the flag bank
module pfb_evt_src
(
    // clock
    input wire logic clock,
    // requests from the bench
    input wire logic [5:0] pulse,
    input wire logic lvl,
    // event lines
    output logic nvWriteDone,
    output logic busCollision,
    output logic lowVoltageLevel,
    output logic timerThreeRollover,
    output logic capEvent,
    output logic cmpMatch
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock)
    begin
        nvWriteDone <= pulse[4];
        busCollision <= pulse[3];
        lowVoltageLevel <= lvl;
        timerThreeRollover <= pulse[1];
        capEvent <= pulse[0];
        cmpMatch <= pulse[5];
    end
endmodule // pfb_evt_src

// [tb/test_pfb_flag_bank.sv]
// self-checking bench for the flag bank
module test_pfb_flag_bank
    import pfb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    logic pready, pslverr, se, irq, lvl = 1'b0;
    logic nvWriteDone, busCollision, lowVoltageLevel, timerThreeRollover, capEvent, cmpMatch;
    logic [5:0] pulse = '0;
    logic [FLAG_W-1:0] eventFlags;
    int bits [3] = '{4, 3, 1};
    int err_count = 0;
    int total_checks = 0;
    always #2.5 clock = ~clock;
    pfb_flag_bank pfb_flag_bank_inst (.clock(clock), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nvWriteDone(nvWriteDone),
        .busCollision(busCollision), .lowVoltageLevel(lowVoltageLevel),
        .timerThreeRollover(timerThreeRollover), .capEvent(capEvent), .cmpMatch(cmpMatch),
        .eventFlags(eventFlags), .irq(irq));
    pfb_evt_src pfb_evt_src_inst (.clock(clock), .pulse(pulse), .lvl(lvl),
        .nvWriteDone(nvWriteDone), .busCollision(busCollision),
        .lowVoltageLevel(lowVoltageLevel), .timerThreeRollover(timerThreeRollover),
        .capEvent(capEvent), .cmpMatch(cmpMatch));
    // ----
    // tasks
    // ----
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        apb(1'b0, a, '0);
        chk(rd, exp);
    endtask
    task automatic fire(input logic [5:0] p);
        @(posedge clock);
        pulse <= p;
        @(posedge clock);
        pulse <= '0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial
    begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++)
            rdchk(12'(4 * i), '0);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk(se, 1'b1);
        rdchk(12'h010, '0);
        rdchk(FLAGS_OFF, '0);
        apb(1'b1, FLAGS_OFF, 32'hffff_ffff);
        rdchk(FLAGS_OFF, 32'h0000_001f);
        apb(1'b1, FLAGS_OFF, '0);
        rdchk(FLAGS_OFF, '0);
        foreach (bits[k])
        begin
            fire(6'h01 << bits[k]);
            idle(20);
            chk(eventFlags, 5'h01 << bits[k]);
            chk(irq, 1'b0);
            apb(1'b1, MASK_OFF, 32'h0000_001f);
            idle(2);
            chk(irq, 1'b1);
            apb(1'b1, STAT_OFF, 32'h1 << bits[k]);
            idle(2);
            chk(irq, 1'b0);
            chk(eventFlags, 5'h01 << bits[k]);
            apb(1'b1, MASK_OFF, '0);
            apb(1'b1, FLAGS_OFF, '0);
            idle(2);
            chk(eventFlags, '0);
        end
        @(posedge clock);
        lvl <= 1'b1;
        idle(10);
        chk(eventFlags, 5'h04);
        apb(1'b1, FLAGS_OFF, '0);
        idle(10);
        chk(eventFlags, '0);
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 2; s++)
            begin
                apb(1'b1, CTRL_OFF, 32'(m));
                fire(s ? 6'h20 : 6'h01);
                idle(4);
                chk(eventFlags[0], (m == 1 && s == 0) || (m == 2 && s == 1));
                apb(1'b1, FLAGS_OFF, '0);
            end
        conclude();
    end
    initial
    begin
        #50000;
        err_count++;
        conclude();
    end
endmodule // test_pfb_flag_bank
